/* File: logic/pprc_map.vh */
`ifndef PPRC_MAP_VH
`define PPRC_MAP_VH
// Register offsets on the plain register port.
`define PPRC_OFS_LEAF      8'h00
`define PPRC_OFS_DESC_PTR  8'h04
`define PPRC_OFS_PAGE_PTR  8'h08
`define PPRC_OFS_PRIV      8'h0C
`define PPRC_OFS_CTRL      8'h10
`define PPRC_OFS_RESULT    8'h14
`define PPRC_OFS_FLAGS     8'h18
`define PPRC_OFS_FAULT     8'h1C
// Control register fields.
`define PPRC_CTRL_START    0
`define PPRC_CTRL_CLR_DONE 1
`define PPRC_CTRL_BUSY     0
`define PPRC_CTRL_DONE     1
`define PPRC_CTRL_FAULT    2
`define PPRC_CTRL_FAULT_PF 3
// Flag positions in the flags register.
`define PPRC_FLAG_CF       0
`define PPRC_FLAG_PF       2
`define PPRC_FLAG_AF       4
`define PPRC_FLAG_ZF       6
`define PPRC_FLAG_SF       7
`define PPRC_FLAG_OF       11
`define PPRC_FLAGS_W       12
// Operation constants.
`define PPRC_LEAF_RESTRICT 8'h0E
`define PPRC_PRIV_KERNEL   2'h0
`define PPRC_DESC_ALIGN    6
`define PPRC_PAGE_ALIGN    12
`define PPRC_DESC_WORDS    16
`define PPRC_TYPE_REG      8'h01
`define PPRC_CODE_OK       32'h00000000
`define PPRC_CODE_LOCKFAIL 32'h00000001
`define PPRC_CODE_NOT_MOD  32'h00000002
`define PPRC_GP_CODE       32'h00000000
// Descriptor flag positions in word 0.
`define PPRC_DFLAG_R       0
`define PPRC_DFLAG_W       1
`define PPRC_DFLAG_X       2
// Reset values.
`define PPRC_RST_WORD      32'h00000000
`define PPRC_RST_LEAF      8'h00
`define PPRC_RST_PRIV      2'h3
`endif

/* File: logic/pprc_align.v */
`default_nettype none
module pprc_align #(
    parameter LSB = 6
) (
    // Address under test.
    input  wire [31:0] i_addr,
    // Misalignment indication.
    output wire        o_misaligned
);
    assign o_misaligned = |i_addr[LSB-1:0];
endmodule // pprc_align
`default_nettype wire

/* File: logic/pprc_desc_scratch.v */
`default_nettype none
`include "pprc_map.vh"
module pprc_desc_scratch #(
    parameter WORDS = 16,
    parameter IW    = 4
) (
    // Clock and reset.
    input  wire          i_clk,
    input  wire          i_rst_n,
    // Word capture.
    input  wire          i_clr,
    input  wire          i_wr,
    input  wire [IW-1:0] i_idx,
    input  wire [31:0]   i_data,
    // Decoded copy.
    output wire [2:0]    o_rwx,
    output reg           o_bad
);
    reg [31:0] mem_ff [0:WORDS-1];
    integer    k;
    integer    j;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (k = 0; k < WORDS; k = k + 1) mem_ff[k] <= `PPRC_RST_WORD;
        end else if (i_clr) begin
            for (k = 0; k < WORDS; k = k + 1) mem_ff[k] <= `PPRC_RST_WORD;
        end else if (i_wr) begin
            mem_ff[i_idx] <= i_data;
        end
    end

    assign o_rwx = mem_ff[0][2:0];

    // Only the three permission bits are defined; everything else must be zero.
    always @* begin
        o_bad = |mem_ff[0][31:3];
        // A loop index of its own keeps this process from sharing a variable with the flops.
        for (j = 1; j < WORDS; j = j + 1) o_bad = o_bad | (|mem_ff[j]);
        // Read without write is the one inconsistent pair.
        if (mem_ff[0][`PPRC_DFLAG_R] && !mem_ff[0][`PPRC_DFLAG_W]) o_bad = 1'b1;
    end
endmodule // pprc_desc_scratch
`default_nettype wire

/* File: logic/pprc_check.v */
`default_nettype none
`include "pprc_map.vh"
module pprc_check #(
    parameter DESC_WORDS = `PPRC_DESC_WORDS,
    parameter IDX_W      = 4
) (
    // Clock and reset.
    input  wire        i_clk,
    input  wire        i_rst_n,
    // Register port.
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    // Descriptor fetch.
    output wire        o_desc_req,
    output wire        o_desc_nonencl_rd,
    output reg  [31:0] o_desc_addr,
    input  wire        i_desc_vld,
    input  wire [31:0] i_desc_data,
    // Page metadata lookup.
    output wire        o_meta_req,
    output reg  [31:0] o_meta_addr,
    input  wire        i_meta_vld,
    input  wire        i_meta_in_cache,
    input  wire        i_meta_valid,
    input  wire [7:0]  i_meta_type,
    input  wire        i_meta_pending,
    input  wire        i_meta_modified,
    input  wire [2:0]  i_meta_rwx,
    input  wire        i_meta_own,
    input  wire        i_owner_init,
    input  wire        i_owner_locked,
    // Concurrency status.
    input  wire        i_busy_access,
    input  wire        i_busy_hold,
    input  wire        i_busy_writer,
    // Metadata commit.
    output reg         o_meta_wr,
    output reg  [2:0]  o_meta_rwx,
    output reg         o_meta_pr,
    output wire        o_page_encl_rw,
    // Fault report.
    output reg         o_fault,
    output reg         o_fault_pf,
    output reg  [31:0] o_fault_code,
    output reg  [31:0] o_fault_addr,
    output wire        o_busy
);
    localparam S_IDLE  = 2'd0;
    localparam S_META  = 2'd1;
    localparam S_FETCH = 2'd2;
    localparam S_EVAL  = 2'd3;

    reg [1:0]                 state_ff;
    reg [7:0]                 leaf_ff;
    reg [31:0]                desc_ptr_ff;
    reg [31:0]                page_ptr_ff;
    reg [1:0]                 priv_ff;
    reg [31:0]                result_ff;
    reg [`PPRC_FLAGS_W-1:0]   flags_ff;
    reg                       done_ff;
    reg                       faulted_ff;
    reg                       fault_kind_ff;
    reg [IDX_W-1:0]           idx_ff;
    reg                       valid_ff;
    reg [7:0]                 type_ff;
    reg                       pend_ff;
    reg                       mod_ff;
    reg [2:0]                 rwx_ff;
    reg                       own_ff;

    wire       desc_mis;
    wire       page_mis;
    wire       scr_bad;
    wire [2:0] scr_rwx;
    wire       start;
    wire       clr_done;
    wire       set_done;
    wire       last_word;

    assign start     = i_wr && (i_addr == `PPRC_OFS_CTRL) && i_wdata[`PPRC_CTRL_START];
    assign clr_done  = i_wr && (i_addr == `PPRC_OFS_CTRL) && i_wdata[`PPRC_CTRL_CLR_DONE];
    assign last_word = (idx_ff == DESC_WORDS[IDX_W-1:0] - 1'b1);

    pprc_align #(
        .LSB          (`PPRC_DESC_ALIGN)
    ) u_desc_align (
        .i_addr       (desc_ptr_ff),
        .o_misaligned (desc_mis)
    );

    pprc_align #(
        .LSB          (`PPRC_PAGE_ALIGN)
    ) u_page_align (
        .i_addr       (page_ptr_ff),
        .o_misaligned (page_mis)
    );

    pprc_desc_scratch #(
        .WORDS  (DESC_WORDS),
        .IW     (IDX_W)
    ) u_scratch (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_clr  (state_ff == S_META),
        .i_wr   ((state_ff == S_FETCH) && i_desc_vld),
        .i_idx  (idx_ff),
        .i_data (i_desc_data),
        .o_rwx  (scr_rwx),
        .o_bad  (scr_bad)
    );

    assign o_busy            = (state_ff != S_IDLE);
    assign o_meta_req        = (state_ff == S_META);
    assign o_desc_req        = (state_ff == S_FETCH);
    assign o_desc_nonencl_rd = (state_ff == S_FETCH);
    assign o_page_encl_rw    = (state_ff == S_META) || o_meta_wr;

    // Done is sticky; a completion in the clearing cycle keeps it set.
    assign set_done = o_fault || ((state_ff == S_EVAL) && !o_fault);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            leaf_ff     <= `PPRC_RST_LEAF;
            desc_ptr_ff <= `PPRC_RST_WORD;
            page_ptr_ff <= `PPRC_RST_WORD;
            priv_ff     <= `PPRC_RST_PRIV;
        end else if (i_wr && !o_busy) begin
            // Operands are frozen while an operation runs.
            case (i_addr)
                `PPRC_OFS_LEAF:     leaf_ff     <= i_wdata[7:0];
                `PPRC_OFS_DESC_PTR: desc_ptr_ff <= i_wdata;
                `PPRC_OFS_PAGE_PTR: page_ptr_ff <= i_wdata;
                `PPRC_OFS_PRIV:     priv_ff     <= i_wdata[1:0];
                default:            leaf_ff     <= leaf_ff;
            endcase
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_ff <= 1'b0;
        end else if (set_done) begin
            done_ff <= 1'b1;
        end else if (clr_done) begin
            done_ff <= 1'b0;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff      <= S_IDLE;
            result_ff     <= `PPRC_CODE_OK;
            flags_ff      <= {`PPRC_FLAGS_W{1'b0}};
            faulted_ff    <= 1'b0;
            fault_kind_ff <= 1'b0;
            idx_ff        <= {IDX_W{1'b0}};
            o_desc_addr   <= `PPRC_RST_WORD;
            o_meta_addr   <= `PPRC_RST_WORD;
            valid_ff      <= 1'b0;
            type_ff       <= 8'h00;
            pend_ff       <= 1'b0;
            mod_ff        <= 1'b0;
            rwx_ff        <= 3'h0;
            own_ff        <= 1'b0;
            o_meta_wr     <= 1'b0;
            o_meta_rwx    <= 3'h0;
            o_meta_pr     <= 1'b0;
            o_fault       <= 1'b0;
            o_fault_pf    <= 1'b0;
            o_fault_code  <= `PPRC_GP_CODE;
            o_fault_addr  <= `PPRC_RST_WORD;
        end else begin
            o_fault   <= 1'b0;
            o_meta_wr <= 1'b0;
            if (i_wr && !o_busy && (i_addr == `PPRC_OFS_FLAGS)) begin
                flags_ff <= i_wdata[`PPRC_FLAGS_W-1:0];
            end
            case (state_ff)
                S_IDLE: begin
                    if (start) begin
                        faulted_ff   <= 1'b0;
                        o_fault_code <= `PPRC_GP_CODE;
                        o_fault_addr <= `PPRC_RST_WORD;
                        idx_ff       <= {IDX_W{1'b0}};
                        o_desc_addr  <= desc_ptr_ff;
                        o_meta_addr  <= page_ptr_ff;
                        if ((priv_ff != `PPRC_PRIV_KERNEL) ||
                            (leaf_ff != `PPRC_LEAF_RESTRICT) ||
                            desc_mis ||
                            page_mis) begin
                            o_fault       <= 1'b1;
                            o_fault_pf    <= 1'b0;
                            faulted_ff    <= 1'b1;
                            fault_kind_ff <= 1'b0;
                        end else begin
                            state_ff <= S_META;
                        end
                    end
                end
                S_META: begin
                    if (i_meta_vld) begin
                        valid_ff <= i_meta_valid;
                        type_ff  <= i_meta_type;
                        pend_ff  <= i_meta_pending;
                        mod_ff   <= i_meta_modified;
                        rwx_ff   <= i_meta_rwx;
                        own_ff   <= i_meta_own;
                        if (!i_meta_in_cache) begin
                            o_fault       <= 1'b1;
                            o_fault_pf    <= 1'b1;
                            o_fault_addr  <= page_ptr_ff;
                            faulted_ff    <= 1'b1;
                            fault_kind_ff <= 1'b1;
                            state_ff      <= S_IDLE;
                        end else begin
                            state_ff <= S_FETCH;
                        end
                    end
                end
                S_FETCH: begin
                    if (i_desc_vld) begin
                        idx_ff      <= idx_ff + 1'b1;
                        o_desc_addr <= o_desc_addr + 32'h00000004;
                        if (last_word) begin
                            state_ff <= S_EVAL;
                        end
                    end
                end
                S_EVAL: begin
                    state_ff <= S_IDLE;
                    if (scr_bad || i_busy_access) begin
                        o_fault       <= 1'b1;
                        o_fault_pf    <= 1'b0;
                        faulted_ff    <= 1'b1;
                        fault_kind_ff <= 1'b0;
                    end else if (!valid_ff) begin
                        o_fault       <= 1'b1;
                        o_fault_pf    <= 1'b1;
                        o_fault_addr  <= page_ptr_ff;
                        faulted_ff    <= 1'b1;
                        fault_kind_ff <= 1'b1;
                    end else if (i_busy_hold || i_busy_writer) begin
                        result_ff                <= `PPRC_CODE_LOCKFAIL;
                        flags_ff                 <= {`PPRC_FLAGS_W{1'b0}};
                        flags_ff[`PPRC_FLAG_ZF]  <= 1'b1;
                    end else if (pend_ff || mod_ff) begin
                        result_ff                <= `PPRC_CODE_NOT_MOD;
                        flags_ff                 <= {`PPRC_FLAGS_W{1'b0}};
                        flags_ff[`PPRC_FLAG_ZF]  <= 1'b1;
                    end else if ((type_ff != `PPRC_TYPE_REG) || !own_ff) begin
                        o_fault       <= 1'b1;
                        o_fault_pf    <= 1'b1;
                        o_fault_addr  <= page_ptr_ff;
                        faulted_ff    <= 1'b1;
                        fault_kind_ff <= 1'b1;
                    end else if (i_owner_locked || !i_owner_init) begin
                        o_fault       <= 1'b1;
                        o_fault_pf    <= 1'b0;
                        faulted_ff    <= 1'b1;
                        fault_kind_ff <= 1'b0;
                    end else begin
                        // Page keeps only rights that both it and the mask grant.
                        o_meta_wr  <= 1'b1;
                        o_meta_pr  <= 1'b1;
                        o_meta_rwx <= rwx_ff & scr_rwx;
                        result_ff  <= `PPRC_CODE_OK;
                        flags_ff   <= {`PPRC_FLAGS_W{1'b0}};
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // A fault leaves result and flags untouched, as an exception would.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= `PPRC_RST_WORD;
        end else if (i_rd) begin
            case (i_addr)
                `PPRC_OFS_LEAF:     o_rdata <= {24'h000000, leaf_ff};
                `PPRC_OFS_DESC_PTR: o_rdata <= desc_ptr_ff;
                `PPRC_OFS_PAGE_PTR: o_rdata <= page_ptr_ff;
                `PPRC_OFS_PRIV:     o_rdata <= {30'h00000000, priv_ff};
                `PPRC_OFS_CTRL:     o_rdata <= {28'h0000000, fault_kind_ff, faulted_ff,
                                                done_ff, o_busy};
                `PPRC_OFS_RESULT:   o_rdata <= result_ff;
                `PPRC_OFS_FLAGS:    o_rdata <= {20'h00000, flags_ff};
                `PPRC_OFS_FAULT:    o_rdata <= o_fault_addr;
                default:            o_rdata <= `PPRC_RST_WORD;
            endcase
        end else begin
            o_rdata <= `PPRC_RST_WORD;
        end
    end
endmodule // pprc_check
`default_nettype wire

/* File: test/pprc_check_checker.sv */
`default_nettype none
module pprc_check_checker #(
    parameter int DESC_WORDS = 16
) (
    // Clock, reset and register port.
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    // Fetch and lookup.
    input wire logic        o_desc_req,
    input wire logic        o_desc_nonencl_rd,
    input wire logic [31:0] o_desc_addr,
    input wire logic        i_desc_vld,
    input wire logic [31:0] i_desc_data,
    input wire logic        o_meta_req,
    input wire logic [31:0] o_meta_addr,
    input wire logic        i_meta_vld,
    input wire logic        i_meta_in_cache,
    input wire logic [2:0]  i_meta_rwx,
    // Outcome.
    input wire logic        o_meta_wr,
    input wire logic [2:0]  o_meta_rwx,
    input wire logic        o_meta_pr,
    input wire logic        o_page_encl_rw,
    input wire logic        o_fault,
    input wire logic        o_fault_pf,
    input wire logic [31:0] o_fault_code,
    input wire logic [31:0] o_fault_addr,
    input wire logic        o_busy
);
    logic [7:0]  leaf_ff;
    logic [1:0]  priv_ff;
    logic [31:0] dptr_ff;
    logic [31:0] pptr_ff;
    logic [2:0]  rwx_ff;
    logic [2:0]  dsc_ff;
    logic [4:0]  words_ff;
    wire         cfg = i_wr && !o_busy;
    wire         start = cfg && i_addr == 8'h10 && i_wdata[0];
    wire         bad = leaf_ff != 8'h0E || priv_ff != 2'h0 || dptr_ff[5:0] != 6'h00
                       || pptr_ff[11:0] != 12'h000;
    wire         take = o_desc_req && i_desc_vld;

    // Shadows follow only writes the block accepts, since it ignores them while busy.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            leaf_ff  <= 8'h00;
            priv_ff  <= 2'h3;
            dptr_ff  <= 32'h00000000;
            pptr_ff  <= 32'h00000000;
            rwx_ff   <= 3'h0;
            dsc_ff   <= 3'h0;
            words_ff <= 5'h00;
        end else begin
            if (cfg && i_addr == 8'h00) leaf_ff <= i_wdata[7:0];
            if (cfg && i_addr == 8'h04) dptr_ff <= i_wdata;
            if (cfg && i_addr == 8'h08) pptr_ff <= i_wdata;
            if (cfg && i_addr == 8'h0C) priv_ff <= i_wdata[1:0];
            if (o_meta_req && i_meta_vld) rwx_ff <= i_meta_rwx;
            if (take && words_ff == 5'h00) dsc_ff <= i_desc_data[2:0];
            words_ff <= start ? 5'h00 : words_ff + {4'h0, take};
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_gp;
        o_fault && !o_fault_pf && o_fault_addr == 32'h00000000 && !o_busy;
    endsequence
    sequence s_pf;
        o_fault && o_fault_pf && o_fault_addr == o_meta_addr && !o_busy;
    endsequence
    sequence s_run;
        o_busy && o_meta_req && o_meta_addr == pptr_ff;
    endsequence
    early_fault_a: assert property (
        start && bad |=> s_gp) else $error("early check gave no clean protection fault");
    run_start_a: assert property (
        start && !bad |=> s_run) else $error("accepted start did not begin lookup");
    no_cache_a: assert property (
        o_meta_req && i_meta_vld && !i_meta_in_cache |=> s_pf) else $error("no page fault");
    fault_code_a: assert property (
        o_fault |-> o_fault_code == 32'h00000000 && !o_meta_wr) else $error("fault code");
    desc_rights_a: assert property (
        o_desc_nonencl_rd == o_desc_req) else $error("descriptor read rights wrong");
    page_rights_a: assert property (
        o_meta_req || o_meta_wr |-> o_page_encl_rw) else $error("page access rights wrong");
    desc_addr_a: assert property (
        o_desc_req |-> o_desc_addr == dptr_ff + {25'h0, words_ff, 2'h0}) else $error("word addr");
    commit_full_a: assert property (
        o_meta_wr |-> words_ff == DESC_WORDS && o_meta_pr && !o_busy) else $error("early commit");
    rights_and_a: assert property (
        o_meta_wr |-> o_meta_rwx == (rwx_ff & dsc_ff)) else $error("committed rights wrong");
endmodule // pprc_check_checker
bind pprc_check pprc_check_checker #(.DESC_WORDS(DESC_WORDS)) u_checker (.*);
`default_nettype wire

/* File: test/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst_n, i_wr, i_rd, i_desc_vld, i_meta_vld, gd;
    logic [7:0]  i_addr, i_meta_type;
    logic [31:0] i_wdata, i_desc_data, o_rdata, o_desc_addr, o_meta_addr, o_fault_code;
    logic [31:0] o_fault_addr, dptr, exp_res, exp_fa;
    logic [2:0]  i_meta_rwx, o_meta_rwx;
    logic        i_meta_in_cache, i_meta_valid, i_meta_pending, i_meta_modified, i_meta_own;
    logic        i_owner_init, i_owner_locked, i_busy_access, i_busy_hold, i_busy_writer;
    logic        o_desc_req, o_desc_nonencl_rd, o_meta_req, o_meta_wr, o_meta_pr;
    logic        o_page_encl_rw, o_fault, o_fault_pf, o_busy;
    logic        rd_d = 1'b0;
    integer      seed = 48289;
    integer      failures = 0;
    integer      checks_done = 0;
    logic [39:0] exp_q[$];
    logic [31:0] desc[16];
    logic [11:0] exp_flg;
    logic [9:0]  env;
    logic [15:0] tbl[19] = '{16'h2000, 16'h4000, 16'h4000, 16'h4000, 16'h6000, 16'h8000,
        16'h0101, 16'h0802, 16'h1000, 16'h0182, 16'h0102, 16'h0110, 16'h0200, 16'h0410,
        16'h0020, 16'h0400, 16'h0004, 16'h0008, 16'h0040};

    pprc_check dut (.*);

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic take(input logic [39:0] seen);
        if (exp_q.size() == 0) check(seen, ~seen);
        else check(seen, exp_q.pop_front());
    endtask

    // Outcomes are matched in order against the notes made by the driver.
    always @(posedge i_clk) begin
        rd_d <= i_rd;
        if (o_fault) take({4'h1, 3'h0, o_fault_pf, o_fault_addr});
        if (o_meta_wr) take({4'h2, 33'h0, o_meta_rwx});
        if (rd_d) take({8'h03, o_rdata});
    end

    // Far side answers after random stalls; idle data lines carry noise, not the last word.
    always @(posedge i_clk) begin
        gd = o_desc_req && !i_desc_vld && $random(seed) % 2 == 0;
        i_meta_vld <= o_meta_req && !i_meta_vld && $random(seed) % 2 == 0;
        i_desc_vld <= gd;
        i_desc_data <= gd ? desc[(o_desc_addr - dptr) >> 2] : $random(seed);
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back({8'h03, want});
        bus(1'b0, a, $random(seed));
    endtask

    task automatic idle;
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic put_env;
        {i_busy_writer, i_busy_hold, i_busy_access, i_owner_locked, i_meta_modified,
         i_meta_pending, i_owner_init, i_meta_own, i_meta_valid, i_meta_in_cache} <= env;
    endtask

    task automatic op(input logic [7:0] lf, input logic [1:0] pv, input logic [31:0] dp,
                      input logic [31:0] pp);
        logic [2:0] r;
        logic       rsv;
        integer     n;
        r = desc[0][2:0];
        rsv = |desc[0][31:3];
        for (n = 1; n < 16; n++) rsv = rsv | (|desc[n]);
        dptr = dp;
        exp_flg = 12'h8D5;
        if (lf != 8'h0E || pv != 2'h0 || dp[5:0] != 6'h00 || pp[11:0] != 12'h000)
            exp_q.push_back({8'h10, 32'h0});
        else if (!i_meta_in_cache) exp_q.push_back({8'h11, pp});
        else if (rsv || (r[0] && !r[1]) || i_busy_access)
            exp_q.push_back({8'h10, 32'h0});
        else if (!i_meta_valid) exp_q.push_back({8'h11, pp});
        else if (i_busy_hold || i_busy_writer) begin
            exp_res = 32'h1;
            exp_flg = 12'h040;
        end else if (i_meta_pending || i_meta_modified) begin
            exp_res = 32'h2;
            exp_flg = 12'h040;
        end else if (i_meta_type != 8'h01 || !i_meta_own)
            exp_q.push_back({8'h11, pp});
        else if (i_owner_locked || !i_owner_init)
            exp_q.push_back({8'h10, 32'h0});
        else begin
            exp_q.push_back({8'h20, 29'h0, r & i_meta_rwx});
            exp_res = 32'h0;
            exp_flg = 12'h000;
        end
        exp_fa = (exp_q.size() != 0 && exp_q[$][39:32] == 8'h11) ? pp : 32'h0;
        bus(1'b1, 8'h18, 32'h000008D5);
        bus(1'b1, 8'h00, {24'h0, lf});
        bus(1'b1, 8'h04, dp);
        bus(1'b1, 8'h08, pp);
        bus(1'b1, 8'h0C, {30'h0, pv});
        bus(1'b1, 8'h10, 32'h00000001);
        idle();
        @(negedge i_clk);
        n = 0;
        while (o_busy !== 1'b0 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 400) begin
            failures++;
            give_verdict();
        end
        @(posedge i_clk);
        rd(8'h14, exp_res);
        rd(8'h18, {20'h0, exp_flg});
        rd(8'h1C, exp_fa);
        idle();
    endtask

    task automatic run(input integer k);
        logic [15:0] t;
        logic [31:0] dp;
        logic [31:0] pp;
        logic [2:0]  dr;
        t = (k < 19) ? tbl[k] : 16'h0000;
        env = 10'h00F ^ t[9:0];
        dp = $random(seed);
        pp = $random(seed);
        dr = 3'($random(seed));
        dp[5:0] = (t[15:13] == 3'h3) ? 6'h20 : 6'h00;
        pp[11:0] = (t[15:13] == 3'h4) ? 12'h800 : 12'h000;
        dr[1] = dr[1] | dr[0];
        foreach (desc[n]) desc[n] = 32'h0;
        desc[0][2:0] = (t[12:11] == 2'h2) ? 3'h1 : dr;
        desc[15][31] = (t[12:11] == 2'h1);
        i_meta_type <= t[10] ? 8'h02 : 8'h01;
        i_meta_rwx <= 3'($random(seed));
        put_env();
        idle();
        op((t[15:13] == 3'h1) ? 8'h0F : 8'h0E, (t[15:13] == 3'h2) ? 2'(k) : 2'h0, dp, pp);
        $display("test %0d done", k);
    endtask

    task automatic give_verdict;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        i_rst_n = 1'b0;
        {i_wr, i_rd, i_desc_vld, i_meta_vld, i_addr, i_wdata, i_desc_data} = '0;
        {i_meta_type, i_meta_rwx, env, dptr, exp_res} = '0;
        put_env();
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int a = 0; a < 9; a++) rd(8'(a * 4), (a == 3) ? 32'h3 : 32'h0);
        bus(1'b1, 8'h04, 32'h89ABCDC0);
        bus(1'b1, 8'h14, 32'h00000005);
        bus(1'b1, 8'h20, 32'h00000007);
        bus(1'b1, 8'h18, 32'h000008D5);
        rd(8'h04, 32'h89ABCDC0);
        rd(8'h14, 32'h00000000);
        rd(8'h20, 32'h00000000);
        rd(8'h18, 32'h000008D5);
        idle();
        $display("test registers done");
        for (int k = 0; k < 27; k++) run(k);
        repeat (3) idle();
        check(40'(exp_q.size()), 40'h0);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
